/* File: verilog/config_nvm_transfer_control.v */
// Storage transfer control: register file, segment list walker, store FIFO.
// Assumes register accesses arrive already decoded from the serial control
// port, and that the storage answers each read with one acknowledge.
`include "config_nvm_map.vh"

module nvm_store_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Filling side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Draining side
    output wire out_valid,
    input wire out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire empty
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (count != DEPTH[AW:0]);
    assign empty = (count == {(AW+1){1'b0}});
    assign out_valid = !empty;
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointers wrap naturally because the depth is a power of two.
    always @(posedge sys_clk) begin
        if (srst) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                mem[wr_ptr] <= in_data;
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop)
                rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop)
                count <= count + 1'b1;
            else if (pop && !push)
                count <= count - 1'b1;
        end
    end
endmodule // nvm_store_fifo

module config_nvm_transfer_control (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Decoded serial control port access
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata,
    output reg reg_rvalid,
    // Storage-select pin, low selects reload from storage
    input wire nvm_sel_n,
    // General status pin
    output reg status_pin,
    // Store stream towards the storage
    output wire nvm_wr_valid,
    input wire nvm_wr_ready,
    output wire [7:0] nvm_wr_addr,
    output wire [7:0] nvm_wr_data,
    // Load requests towards the storage
    output reg nvm_rd_req,
    output reg [7:0] nvm_rd_addr,
    input wire nvm_rd_ack,
    input wire [7:0] nvm_rd_data,
    input wire nvm_rd_err,
    // Active bank update strobe
    output reg active_update
);
    localparam S_IDLE = 3'd0;
    localparam S_OP = 3'd1;
    localparam S_ADDR = 3'd2;
    localparam S_MOVE = 3'd3;
    localparam S_WAIT = 3'd4;
    localparam S_DRAIN = 3'd5;

    reg [7:0] buf_bank [0:`BUF_WORDS-1];
    reg [7:0] act_bank [0:`BUF_WORDS-1];
    reg [7:0] seg [0:`SEG_COUNT-1];
    reg [2:0] state;
    reg dir_store;
    reg [4:0] idx;
    reg [6:0] cnt;
    reg [5:0] baddr;
    reg [7:0] naddr;
    reg wen;
    reg err;
    reg store_cmd;
    reg soft_bit;
    reg host_update;
    reg list_update;
    wire busy;
    wire in_buf;
    wire in_seg;
    wire [7:0] entry;
    wire fifo_in_valid;
    wire fifo_in_ready;
    wire fifo_empty;
    wire do_update;
    wire start_store;
    wire [11:0] seg_base = `SEG_BASE_ADDR;
    wire [11:0] sel_addr = `STATUS_SEL_ADDR;
    integer i;

    assign busy = (state != S_IDLE);
    assign in_buf = (reg_addr[11:6] == 6'h00);
    assign in_seg = (reg_addr[11:5] == seg_base[11:5])
        && (reg_addr[4:0] <= `SEG_LAST_IDX);
    assign entry = seg[idx];
    assign do_update = host_update || list_update;
    // A store is started only with write protection lifted and no transfer running.
    assign start_store = reg_wr && (reg_addr == `STORE_ADDR)
        && reg_wdata[`FLAG_BIT] && wen && !busy && !soft_bit;
    assign fifo_in_valid = (state == S_MOVE) && dir_store;

    // Store data passes through a small FIFO so a slow storage stalls the walker.
    nvm_store_fifo #(
        .WIDTH(`FIFO_WIDTH),
        .DEPTH(`FIFO_DEPTH),
        .AW(2)
    ) u_fifo (
        .sys_clk(sys_clk),
        .srst(srst),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .in_data({naddr, buf_bank[baddr]}),
        .out_valid(nvm_wr_valid),
        .out_ready(nvm_wr_ready),
        .out_data({nvm_wr_addr, nvm_wr_data}),
        .empty(fifo_empty)
    );

    // Host control bits; self-clearing bits drop without a host write.
    always @(posedge sys_clk) begin
        if (srst) begin
            wen <= `WEN_RESET;
            soft_bit <= 1'b0;
            host_update <= 1'b0;
            store_cmd <= 1'b0;
        end else begin
            soft_bit <= reg_wr && (reg_addr == `SOFT_RELOAD_ADDR)
                && reg_wdata[`SOFT_RELOAD_BIT] && !nvm_sel_n && !busy;
            host_update <= reg_wr && (reg_addr == `ACTIVE_UPDATE_ADDR)
                && reg_wdata[`FLAG_BIT];
            if (soft_bit)
                wen <= `WEN_RESET;
            else if (reg_wr && (reg_addr == `WEN_ADDR))
                wen <= reg_wdata[`FLAG_BIT];
            // Without write enable the command never latches, so it reads 0.
            if (start_store)
                store_cmd <= 1'b1;
            else if (state == S_DRAIN && fifo_empty)
                store_cmd <= 1'b0;
        end
    end

    // Segment list walker for both directions.
    always @(posedge sys_clk) begin
        if (srst) begin
            state <= S_IDLE;
            dir_store <= 1'b0;
            idx <= 5'd0;
            cnt <= 7'd0;
            baddr <= 6'd0;
            naddr <= 8'h00;
            err <= 1'b0;
            nvm_rd_req <= 1'b0;
            nvm_rd_addr <= 8'h00;
            list_update <= 1'b0;
        end else begin
            list_update <= 1'b0;
            nvm_rd_req <= 1'b0;
            case (state)
                S_IDLE: begin
                    idx <= 5'd0;
                    naddr <= 8'h00;
                    if (start_store || soft_bit) begin
                        dir_store <= start_store;
                        err <= 1'b0;
                        state <= S_OP;
                    end
                end
                S_OP: begin
                    if (entry == `OP_END || idx > `SEG_LAST_IDX) begin
                        state <= dir_store ? S_DRAIN : S_IDLE;
                    end else if (entry == `OP_UPDATE) begin
                        list_update <= 1'b1;
                        idx <= idx + 5'd1;
                    end else begin
                        cnt <= entry[6:0];
                        idx <= idx + 5'd1;
                        state <= S_ADDR;
                    end
                end
                S_ADDR: begin
                    baddr <= seg[idx][5:0];
                    idx <= idx + 5'd1;
                    state <= (cnt == 7'd0) ? S_OP : S_MOVE;
                end
                S_MOVE: begin
                    if (dir_store) begin
                        if (fifo_in_ready) begin
                            baddr <= baddr + 6'd1;
                            naddr <= naddr + 8'h01;
                            cnt <= cnt - 7'd1;
                            if (cnt == 7'd1)
                                state <= S_OP;
                        end
                    end else begin
                        nvm_rd_req <= 1'b1;
                        nvm_rd_addr <= naddr;
                        state <= S_WAIT;
                    end
                end
                S_WAIT: begin
                    if (nvm_rd_ack) begin
                        if (nvm_rd_err)
                            err <= 1'b1;
                        baddr <= baddr + 6'd1;
                        naddr <= naddr + 8'h01;
                        cnt <= cnt - 7'd1;
                        state <= (cnt == 7'd1) ? S_OP : S_MOVE;
                    end
                end
                S_DRAIN: begin
                    // The store ends only once the last byte has left the FIFO.
                    if (fifo_empty)
                        state <= S_IDLE;
                end
                default: state <= S_IDLE;
            endcase
        end
    end

    // Buffer bank and segment list; host writes are ignored during a transfer.
    always @(posedge sys_clk) begin
        if (srst || soft_bit) begin
            for (i = 0; i < `BUF_WORDS; i = i + 1)
                buf_bank[i] <= `BUF_RESET;
            for (i = 0; i < `SEG_COUNT; i = i + 1)
                seg[i] <= `OP_END;
            seg[0] <= `SEG_DEF_CNT;
            seg[1] <= `SEG_DEF_ADDR;
            seg[2] <= `OP_UPDATE;
        end else if (state == S_WAIT && nvm_rd_ack) begin
            buf_bank[baddr] <= nvm_rd_data;
        end else if (reg_wr && !busy) begin
            if (in_buf)
                buf_bank[reg_addr[5:0]] <= reg_wdata;
            if (in_seg)
                seg[reg_addr[4:0]] <= reg_wdata;
        end
    end

    // Active bank takes the whole buffer bank on an update.
    always @(posedge sys_clk) begin
        if (srst) begin
            for (i = 0; i < `BUF_WORDS; i = i + 1)
                act_bank[i] <= `BUF_RESET;
            active_update <= 1'b0;
        end else begin
            active_update <= do_update;
            if (do_update) begin
                for (i = 0; i < `BUF_WORDS; i = i + 1)
                    act_bank[i] <= buf_bank[i];
            end
        end
    end

    // Status pin follows busy when the active select bit is set.
    always @(posedge sys_clk) begin
        if (srst)
            status_pin <= 1'b0;
        else
            status_pin <= act_bank[sel_addr[5:0]][`STATUS_SEL_BIT] && busy;
    end

    // Read data is registered and answered one cycle after the strobe.
    always @(posedge sys_clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
            if (reg_rd) begin
                reg_rdata <= 8'h00;
                if (in_buf)
                    reg_rdata <= buf_bank[reg_addr[5:0]];
                else if (in_seg)
                    reg_rdata <= seg[reg_addr[4:0]];
                else if (reg_addr == `BUSY_ADDR)
                    reg_rdata <= {7'd0, busy};
                else if (reg_addr == `ERROR_ADDR)
                    reg_rdata <= {7'd0, err};
                else if (reg_addr == `WEN_ADDR)
                    reg_rdata <= {7'd0, wen};
                else if (reg_addr == `STORE_ADDR)
                    reg_rdata <= {7'd0, store_cmd};
                else if (reg_addr == `SOFT_RELOAD_ADDR)
                    reg_rdata <= {6'd0, soft_bit, 1'b0};
            end
        end
    end
endmodule // config_nvm_transfer_control

/* File: verilog/config_nvm_map.vh */
// Register map, field positions, reset values and list opcodes of the
// configuration storage transfer control.
// Assumes inclusion by bare name from the design file that uses it.
`ifndef CONFIG_NVM_MAP_VH
`define CONFIG_NVM_MAP_VH

// Register offsets on the serial control port.
`define STATUS_SEL_ADDR 12'h01D
`define ACTIVE_UPDATE_ADDR 12'h232
`define SOFT_RELOAD_ADDR 12'h302
`define SEG_BASE_ADDR 12'hA00
`define SEG_LAST_ADDR 12'hA16
`define BUSY_ADDR 12'hB00
`define ERROR_ADDR 12'hB01
`define WEN_ADDR 12'hB02
`define STORE_ADDR 12'hB03

// Field positions.
`define STATUS_SEL_BIT 7
`define SOFT_RELOAD_BIT 1
`define FLAG_BIT 0

// Reset values.
`define WEN_RESET 1'b0
`define BUF_RESET 8'h00

// Segment list sizes and opcodes.
`define SEG_COUNT 23
`define SEG_LAST_IDX 5'h16
`define OP_UPDATE 8'h80
`define OP_END 8'hFF
`define SEG_DEF_CNT 8'h40
`define SEG_DEF_ADDR 8'h00

// Buffer register bank covers offsets 0x000 to 0x03F.
`define BUF_WORDS 64
`define FIFO_DEPTH 4
`define FIFO_WIDTH 16

`endif

/* File: verification/config_nvm_assertions.sv */
// Concurrent checks on the ports of the storage transfer control.
// Assumes the map header is on the include path; bound after the module.
`include "config_nvm_map.vh"
module config_nvm_checker (
    // Clock and reset
    input wire sys_clk,
    input wire srst,
    // Register port
    input wire [11:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire reg_rvalid,
    // Storage side
    input wire nvm_wr_valid,
    input wire nvm_wr_ready,
    input wire [7:0] nvm_wr_addr,
    input wire [7:0] nvm_wr_data,
    input wire nvm_rd_req,
    input wire [7:0] nvm_rd_addr,
    input wire active_update
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (srst);
    // A store word handed over, or held back by the storage.
    sequence wr_take;
        nvm_wr_valid && nvm_wr_ready;
    endsequence
    sequence wr_stall;
        nvm_wr_valid && !nvm_wr_ready;
    endsequence
    // Read answers come exactly one cycle after the strobe.
    rd_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("read not answered next cycle");
    rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
        else $error("read answer without a read");
    // A stalled word keeps its address and data.
    wr_hold_a: assert property (wr_stall |=> nvm_wr_valid && $stable(nvm_wr_addr)
        && $stable(nvm_wr_data)) else $error("store word changed while stalled");
    // The default list stores consecutive addresses.
    wr_order_a: assert property (wr_take ##1 nvm_wr_valid |->
        nvm_wr_addr == $past(nvm_wr_addr) + 8'h01) else $error("store address skipped");
    // Load requests are single pulses with a steady address.
    req_pulse_a: assert property (nvm_rd_req |=> !nvm_rd_req)
        else $error("load request longer than one cycle");
    req_addr_a: assert property (!nvm_rd_req |-> $stable(nvm_rd_addr))
        else $error("load address moved without a request");
    load_store_a: assert property (nvm_rd_req |-> !nvm_wr_valid)
        else $error("load and store at once");
    // Host update lands in the active bank within two cycles of the write.
    update_strobe_a: assert property (reg_wr && reg_addr == `ACTIVE_UPDATE_ADDR &&
        reg_wdata[0] |-> ##[1:2] active_update) else $error("update not applied");
    update_pulse_a: assert property (active_update |=> !active_update)
        else $error("update strobe longer than one cycle");
endmodule // config_nvm_checker

bind config_nvm_transfer_control config_nvm_checker chk (.sys_clk, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rvalid, .nvm_wr_valid, .nvm_wr_ready, .nvm_wr_addr,
    .nvm_wr_data, .nvm_rd_req, .nvm_rd_addr, .active_update);

/* File: verification/nvm_storage_model.sv */
// Behavioural model of the nonvolatile storage behind the transfer control.
// Assumes one outstanding load request; ready toggles each cycle to stall every other cycle.
module nvm_storage_model (
    // Clock
    input wire sys_clk,
    // Store stream
    input wire nvm_wr_valid,
    output logic nvm_wr_ready,
    input wire [7:0] nvm_wr_addr,
    input wire [7:0] nvm_wr_data,
    // Load requests
    input wire nvm_rd_req,
    input wire [7:0] nvm_rd_addr,
    output logic nvm_rd_ack,
    output logic [7:0] nvm_rd_data,
    output logic nvm_rd_err,
    // Bench control and counts
    input wire [8:0] err_at,
    output int n_wr,
    output int n_rd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [256];
    logic [1:0] wait_cnt = 2'd0;
    logic pend = 1'b0;
    initial begin
        nvm_wr_ready = 1'b0;
        nvm_rd_ack = 1'b0;
        nvm_rd_data = 8'h00;
        nvm_rd_err = 1'b0;
        n_wr = 0;
        n_rd = 0;
        foreach (mem[i]) mem[i] = 8'h00;
    end
    // Stores words, answers loads after a delay and scrambles idle data.
    always @(posedge sys_clk) begin
        nvm_wr_ready <= ~nvm_wr_ready;
        if (nvm_wr_valid && nvm_wr_ready) begin
            mem[nvm_wr_addr] <= nvm_wr_data;
            n_wr <= n_wr + 1;
        end
        nvm_rd_ack <= 1'b0;
        nvm_rd_err <= 1'b0;
        nvm_rd_data <= ~nvm_rd_data;
        if (nvm_rd_req) begin
            pend <= 1'b1;
            wait_cnt <= 2'd2;
            n_rd <= n_rd + 1;
        end else if (pend && wait_cnt != 2'd0) begin
            wait_cnt <= wait_cnt - 2'd1;
        end else if (pend) begin
            nvm_rd_ack <= 1'b1;
            nvm_rd_data <= mem[nvm_rd_addr];
            nvm_rd_err <= (err_at == {1'b0, nvm_rd_addr});
            pend <= 1'b0;
        end
    end
endmodule // nvm_storage_model

/* File: verification/tb_top.sv */
// Self-checking bench of the storage transfer control with a storage model.
// Assumes the design, the map header and the model compile ahead of it.
`include "config_nvm_map.vh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic nvm_sel_n = 1'b1;
    logic [8:0] err_at = 9'h100;
    wire [7:0] reg_rdata;
    wire reg_rvalid, status_pin, nvm_wr_valid, nvm_wr_ready, nvm_rd_req;
    wire nvm_rd_ack, nvm_rd_err, active_update;
    wire [7:0] nvm_wr_addr, nvm_wr_data, nvm_rd_addr, nvm_rd_data;
    int miscompares = 0;
    int n_compared = 0;
    int n_wr, n_rd;
    int n_upd = 0;
    int u0;
    config_nvm_transfer_control DUT (.sys_clk, .srst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .reg_rvalid, .nvm_sel_n, .status_pin, .nvm_wr_valid,
        .nvm_wr_ready, .nvm_wr_addr, .nvm_wr_data, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_ack,
        .nvm_rd_data, .nvm_rd_err, .active_update);
    nvm_storage_model store (.sys_clk, .nvm_wr_valid, .nvm_wr_ready, .nvm_wr_addr,
        .nvm_wr_data, .nvm_rd_req, .nvm_rd_addr, .nvm_rd_ack, .nvm_rd_data, .nvm_rd_err,
        .err_at, .n_wr, .n_rd);
    // Clock and update strobe count.
    always #5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (active_update === 1'b1) n_upd <= n_upd + 1;
    function automatic logic [7:0] pat(input int i);
        return i[7:0] ^ 8'hA5;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One write strobe, driven on the falling edge.
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
    endtask
    // One read; the answer stands in the cycle after the strobe is taken.
    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        check({7'h00, reg_rvalid}, 8'h01);
        d = reg_rdata;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(d, exp);
    endtask
    // Polls the busy flag until a transfer ends, within a bounded count.
    task automatic wait_idle();
        logic [7:0] d;
        d = 8'h01;
        for (int k = 0; k < 300 && d[0] !== 1'b0; k++) rd(`BUSY_ADDR, d);
        check(d, 8'h00);
    endtask
    task automatic final_report();
        $display("compared=%0d miscompares=%0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Watchdog for a hung transfer.
    initial begin
        #200000;
        miscompares++;
        final_report();
    end
    // Main sequence.
    initial begin
        repeat (20) @(posedge sys_clk);
        @(negedge sys_clk) srst = 1'b0;
        rdc(`WEN_ADDR, 8'h00);
        rdc(`BUSY_ADDR, 8'h00);
        rdc(`ERROR_ADDR, 8'h00);
        rdc(12'h7FF, 8'h00);
        wr(`STORE_ADDR, 8'h01);
        rdc(`STORE_ADDR, 8'h00);
        repeat (20) @(negedge sys_clk);
        check(n_wr[7:0], 8'h00);
        for (int i = 0; i < `BUF_WORDS; i++) wr(i[11:0], pat(i));
        wr(`ACTIVE_UPDATE_ADDR, 8'h01);
        wr(`WEN_ADDR, 8'h01);
        rdc(`WEN_ADDR, 8'h01);
        wr(`STORE_ADDR, 8'h01);
        rdc(`BUSY_ADDR, 8'h01);
        check({7'h00, status_pin}, 8'h01);
        rdc(`STORE_ADDR, 8'h01);
        wait_idle();
        rdc(`STORE_ADDR, 8'h00);
        check({7'h00, status_pin}, 8'h00);
        for (int i = 0; i < `BUF_WORDS; i++) check(store.mem[i], pat(i));
        check(n_wr[7:0], 8'h40);
        wr(12'h005, 8'h00);
        wr(`SOFT_RELOAD_ADDR, 8'h02);
        repeat (10) @(negedge sys_clk);
        check(n_rd[7:0], 8'h00);
        nvm_sel_n = 1'b0;
        u0 = n_upd;
        wr(`SOFT_RELOAD_ADDR, 8'h02);
        wait_idle();
        rdc(`SOFT_RELOAD_ADDR, 8'h00);
        rdc(12'h005, pat(5));
        rdc(`WEN_ADDR, 8'h00);
        rdc(`ERROR_ADDR, 8'h00);
        check(n_rd[7:0], 8'h40);
        check({7'h00, n_upd > u0}, 8'h01);
        err_at = 9'h003;
        wr(`SOFT_RELOAD_ADDR, 8'h02);
        wait_idle();
        rdc(`ERROR_ADDR, 8'h01);
        // Two-byte list from buffer offset 0x10 with no update, status select cleared.
        wr(12'h01D, 8'h00);
        wr(`ACTIVE_UPDATE_ADDR, 8'h01);
        wr(`WEN_ADDR, 8'h01);
        wr(`SEG_BASE_ADDR, 8'h02);
        wr(`SEG_BASE_ADDR + 12'h001, 8'h10);
        wr(`SEG_BASE_ADDR + 12'h002, `OP_END);
        rdc(`SEG_BASE_ADDR, 8'h02);
        u0 = n_upd;
        wr(`STORE_ADDR, 8'h01);
        rdc(`BUSY_ADDR, 8'h01);
        check({7'h00, status_pin}, 8'h00);
        wait_idle();
        rdc(`ERROR_ADDR, 8'h00);
        check(store.mem[0], pat(16));
        check(store.mem[1], pat(17));
        check(store.mem[2], pat(2));
        check(n_wr[7:0], 8'h42);
        check({7'h00, n_upd == u0}, 8'h01);
        final_report();
    end
endmodule // tb_top
